// [rtl/isc_pkg.sv]
`default_nettype none
// Shared constants for the interrupt sources and time base block.
package isc_pkg;
  // Register file geometry.
  localparam int          ADDR_W      = 3;
  localparam int          DATA_W      = 8;
  localparam logic [2:0]  OFF_PSC     = 3'h0;
  localparam logic [2:0]  OFF_TB0     = 3'h1;
  localparam logic [2:0]  OFF_TB1     = 3'h2;
  localparam logic [2:0]  OFF_EDGE    = 3'h3;
  localparam logic [2:0]  OFF_EN_LO   = 3'h4;
  localparam logic [2:0]  OFF_EN_HI   = 3'h5;
  localparam logic [2:0]  OFF_FLAG_LO = 3'h6;
  localparam logic [2:0]  OFF_FLAG_HI = 3'h7;

  // Field positions.
  localparam int TB_RUN_BIT  = 7;
  localparam int TB_SEL_MSB  = 2;
  localparam int PSC_SEL_MSB = 1;
  localparam int HI_NVM_BIT  = 0;
  localparam int HI_GE_BIT   = 1;
  localparam int EDGE_W      = 2;
  localparam int NUM_PINS    = 2;

  // Reset values.
  localparam logic [1:0] PSC_RST  = 2'h0;
  localparam logic [2:0] SEL_RST  = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Prescaler source codes; any code with the top bit set is the slow clock.
  localparam logic [1:0] PSC_SYS  = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // Edge select codes.
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Time base divider: period is 2^(8 + code) prescaler ticks.
  localparam int          TB_CNT_W    = 15;
  localparam logic [2:0]  TB_MAX_SEL  = 3'h7;
  localparam logic [14:0] TB_FULL     = 15'h7fff;
  localparam logic [14:0] TB_CNT_RST  = 15'h0000;

  // Request sources; a lower index wins when several are pending.
  localparam int NUM_SRC    = 9;
  localparam int VEC_W      = 4;
  localparam int SRC_EXT0   = 0;
  localparam int SRC_EXT1   = 1;
  localparam int SRC_MEAS   = 2;
  localparam int SRC_PMATCH = 3;
  localparam int SRC_DMATCH = 4;
  localparam int SRC_LOWSUP = 5;
  localparam int SRC_TICK0  = 6;
  localparam int SRC_TICK1  = 7;
  localparam int SRC_NVM    = 8;
  localparam logic [8:0] SRC_NONE = 9'h000;
  localparam logic [8:0] SRC_ONE  = 9'h001;
  localparam logic [3:0] VEC_RST  = 4'h0;
endpackage
`default_nettype wire

// [rtl/isc_time_base.sv]
`default_nettype none
// One time base divider. It counts prescaler ticks while running and
// emits a one-cycle overflow every 2^(8+period_sel) ticks.
module isc_time_base (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] period_sel_i,
  output logic            ovf_o
);
  logic [14:0] cnt_r;
  logic [14:0] cnt_nxt;
  logic [14:0] mask;
  logic        wrap;

  // The counter is free running over its full width, so comparing only
  // the selected low bits gives every period without a reload value.
  assign mask    = isc_pkg::TB_FULL >> (isc_pkg::TB_MAX_SEL - period_sel_i);
  assign wrap    = (cnt_r & mask) == mask;
  assign ovf_o   = run_i & tick_i & wrap;
  assign cnt_nxt = !run_i ? isc_pkg::TB_CNT_RST :
                   tick_i ? cnt_r + 15'h0001 : cnt_r;

  // A stopped divider restarts from zero so the first period is whole.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= isc_pkg::TB_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// [rtl/isc_irq_ctrl.sv]
`default_nettype none
// Overview of operation
// - Chosen pin edge sets its external flag.
// - External vector needs global and pin enable.
// - Pin qualifies: enabled, input, interrupt function.
// - External call needs enable, stack room, edge.
// - External service clears flag and global enable.
// - Pull-high selection stays active on interrupt pins.
// - Edge select: rising, falling, both or off.
// - Either measure timer overflow sets shared flag.
// - Two compare matches, separate flags and vectors.
// - Compare service clears its flag, global enable.
// - Low supply sets flag, vectored when allowed.
// - Each time base overflow sets its flag.
// - Time base service clears flag, global enable.
// - Prescaler source: system, system/4, slow clock.
// - Time base zero runs while bit seven set.
// - Period is 2^(8+code) prescaler clocks.
// - Time base one matches time base zero.
// - Write done sets flag, vectored when allowed.
// - Unimplemented control bits ignore writes, read zero.
// - Any flag rising wakes device, enable ignored.
// - No acknowledge while return stack is full.
// - Return from interrupt sets global enable again.
module isc_irq_ctrl (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // Register port.
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  // External interrupt pins and their pin configuration.
  input  wire logic [1:0] ext_irq_pins_i,
  input  wire logic [1:0] pin_is_input_i,
  input  wire logic [1:0] pin_func_irq_i,
  input  wire logic [1:0] pull_high_sel_i,
  output logic      [1:0] pull_high_o,
  // Peripheral events, one-cycle pulses.
  input  wire logic       timer_a_ovf_i,
  input  wire logic       timer_b_ovf_i,
  input  wire logic       period_match_i,
  input  wire logic       duty_match_i,
  input  wire logic       low_supply_i,
  input  wire logic       nvm_write_done_i,
  input  wire logic       slow_aux_tick_i,
  // Program sequencer side.
  input  wire logic       stack_full_i,
  input  wire logic       return_from_irq_i,
  output logic            irq_call_o,
  output logic      [3:0] irq_vector_o,
  output logic            global_irq_enable_o,
  output logic            wake_o
);
  // Control registers hold implemented bits only.
  logic [1:0] prescaler_src_sel_r;
  logic       tick_run_r [2];
  logic [2:0] tick_period_sel_r [2];
  logic [3:0] edge_select_reg_r;
  logic [8:0] irq_en_r;
  logic       global_irq_enable_r;
  logic       global_irq_enable_nxt;
  logic [8:0] flags_r;
  logic [8:0] flags_nxt;
  logic [7:0] rdata_r;
  logic       wake_r;
  logic       call_r;
  logic [3:0] vec_r;
  logic [1:0] pull_high_r;
  logic [1:0] div_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] prev_r;

  // Lowest numbered pending source wins.
  function automatic logic [3:0] first_set(input logic [8:0] v);
    logic [3:0] idx;
    idx = isc_pkg::VEC_RST;
    for (int i = isc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Register write decode.
  wire wr_psc     = we_i && (addr_i == isc_pkg::OFF_PSC);
  wire wr_tb0     = we_i && (addr_i == isc_pkg::OFF_TB0);
  wire wr_tb1     = we_i && (addr_i == isc_pkg::OFF_TB1);
  wire wr_edge    = we_i && (addr_i == isc_pkg::OFF_EDGE);
  wire wr_en_lo   = we_i && (addr_i == isc_pkg::OFF_EN_LO);
  wire wr_en_hi   = we_i && (addr_i == isc_pkg::OFF_EN_HI);
  wire wr_flag_lo = we_i && (addr_i == isc_pkg::OFF_FLAG_LO);
  wire wr_flag_hi = we_i && (addr_i == isc_pkg::OFF_FLAG_HI);
  wire [1:0] wr_tb = {wr_tb1, wr_tb0};

  // Prescaler tick: every clock, every fourth clock, or the slow tick.
  wire div4_tick = (div_r == isc_pkg::DIV4_LAST);
  wire psc_tick  = prescaler_src_sel_r[isc_pkg::PSC_SEL_MSB] ?
                   slow_aux_tick_i :
                   (prescaler_src_sel_r == isc_pkg::PSC_DIV4) ? div4_tick :
                   1'b1;
  wire [1:0] tb_ovf;
  wire [1:0] ext_ev;

  // Both time bases share one prescaler and one divider design.
  for (genvar t = 0; t < 2; t++) begin : g_tick
    isc_time_base u_tb (
      .clock_i      (clock_i),
      .sys_rst_i    (sys_rst_i),
      .run_i        (tick_run_r[t]),
      .tick_i       (psc_tick),
      .period_sel_i (tick_period_sel_r[t]),
      .ovf_o        (tb_ovf[t])
    );
  end

  // Edge decode per pin on the synchronised, delayed samples.
  for (genvar p = 0; p < isc_pkg::NUM_PINS; p++) begin : g_pin
    wire [1:0] code = edge_select_reg_r[p*isc_pkg::EDGE_W +: isc_pkg::EDGE_W];
    wire rise   = sync2_r[p] & ~prev_r[p];
    wire fall   = ~sync2_r[p] & prev_r[p];
    wire want_r = (code == isc_pkg::EDGE_RISE) || (code == isc_pkg::EDGE_BOTH);
    wire want_f = (code == isc_pkg::EDGE_FALL) || (code == isc_pkg::EDGE_BOTH);
    // The pin only counts while it is enabled, an input and muxed in.
    wire pin_ok = irq_en_r[p] & pin_is_input_i[p] & pin_func_irq_i[p];
    assign ext_ev[p] = pin_ok & ((want_r & rise) | (want_f & fall));
  end

  // Hardware set events in source order.
  wire [8:0] set_ev = {nvm_write_done_i,
                       tb_ovf,
                       low_supply_i,
                       duty_match_i,
                       period_match_i,
                       timer_a_ovf_i | timer_b_ovf_i,
                       ext_ev};

  // Vector selection. A request is taken only with the global enable on,
  // its own enable on and room on the return stack.
  wire [8:0] pending  = flags_r & irq_en_r;
  wire       call_go  = global_irq_enable_r && (|pending) &&
                        !stack_full_i;
  wire [3:0] call_vec = first_set(pending);
  wire [8:0] svc_clr  = call_go ? (isc_pkg::SRC_ONE << call_vec) :
                        isc_pkg::SRC_NONE;

  // Software writes to the flag registers act like ordinary storage.
  wire [8:0] flag_wmask = {wr_flag_hi, {8{wr_flag_lo}}};
  wire [8:0] flag_wval  = {wdata_i[isc_pkg::HI_NVM_BIT], wdata_i};

  // Servicing clears the taken flag; a new event in the same cycle is
  // kept, since losing it would drop a request silently.
  assign flags_nxt = ((((flags_r & ~flag_wmask) | (flag_wval & flag_wmask))
                     & ~svc_clr) | set_ev);

  // Taking a vector clears the global enable; return sets it again, and
  // a plain return has no input here so it leaves the enable alone.
  assign global_irq_enable_nxt =
    call_go           ? 1'b0 :
    return_from_irq_i ? 1'b1 :
    wr_en_hi          ? wdata_i[isc_pkg::HI_GE_BIT] :
    global_irq_enable_r;

  // Read selection; bits without storage read as zero.
  wire [7:0] rd_val =
    (addr_i == isc_pkg::OFF_PSC)  ? {6'h00, prescaler_src_sel_r} :
    (addr_i == isc_pkg::OFF_TB0)  ? {tick_run_r[0], 4'h0,
                                     tick_period_sel_r[0]} :
    (addr_i == isc_pkg::OFF_TB1)  ? {tick_run_r[1], 4'h0,
                                     tick_period_sel_r[1]} :
    (addr_i == isc_pkg::OFF_EDGE) ? {4'h0, edge_select_reg_r} :
    (addr_i == isc_pkg::OFF_EN_LO) ? irq_en_r[7:0] :
    (addr_i == isc_pkg::OFF_EN_HI) ? {6'h00, global_irq_enable_r,
                                      irq_en_r[isc_pkg::SRC_NVM]} :
    (addr_i == isc_pkg::OFF_FLAG_LO) ? flags_r[7:0] :
    {7'h00, flags_r[isc_pkg::SRC_NVM]};

  // Pin synchroniser plus one stage of history for edge detection.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r  <= 2'h0;
    end else begin
      sync1_r <= ext_irq_pins_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Free running divide-by-four for the system/4 prescaler source.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= isc_pkg::PSC_SYS;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // Prescaler and edge select registers keep implemented bits only.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescaler_src_sel_r <= isc_pkg::PSC_RST;
      edge_select_reg_r   <= 4'h0;
    end else begin
      if (wr_psc) begin
        prescaler_src_sel_r <= wdata_i[isc_pkg::PSC_SEL_MSB:0];
      end
      if (wr_edge) begin
        edge_select_reg_r <= wdata_i[3:0];
      end
    end
  end

  // Time base control: run bit and period field, one loop for both.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int t = 0; t < 2; t++) begin
        tick_run_r[t]        <= 1'b0;
        tick_period_sel_r[t] <= isc_pkg::SEL_RST;
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (wr_tb[t]) begin
          tick_run_r[t]        <= wdata_i[isc_pkg::TB_RUN_BIT];
          tick_period_sel_r[t] <= wdata_i[isc_pkg::TB_SEL_MSB:0];
        end
      end
    end
  end

  // Enables, global enable and request flags.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_en_r            <= isc_pkg::SRC_NONE;
      global_irq_enable_r <= 1'b0;
      flags_r             <= isc_pkg::SRC_NONE;
    end else begin
      if (wr_en_lo) begin
        irq_en_r[7:0] <= wdata_i;
      end
      if (wr_en_hi) begin
        irq_en_r[isc_pkg::SRC_NVM] <= wdata_i[isc_pkg::HI_NVM_BIT];
      end
      global_irq_enable_r <= global_irq_enable_nxt;
      flags_r             <= flags_nxt;
    end
  end

  // Registered outputs: call pulse with vector, wake pulse, read data.
  // Wake looks at every flag, so masking a source other than a pin does not stop it; a pin enable gates its flag.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      call_r      <= 1'b0;
      vec_r       <= isc_pkg::VEC_RST;
      wake_r      <= 1'b0;
      rdata_r     <= isc_pkg::BYTE_RST;
      pull_high_r <= 2'h0;
    end else begin
      call_r      <= call_go;
      vec_r       <= call_go ? call_vec : vec_r;
      wake_r      <= |(flags_nxt & ~flags_r);
      rdata_r     <= re_i ? rd_val : isc_pkg::BYTE_RST;
      pull_high_r <= pull_high_sel_i;
    end
  end

  assign rdata_o             = rdata_r;
  assign irq_call_o          = call_r;
  assign irq_vector_o        = vec_r;
  assign global_irq_enable_o = global_irq_enable_r;
  assign wake_o              = wake_r;
  assign pull_high_o         = pull_high_r;
endmodule
`default_nettype wire

// [verification/isc_irq_ctrl_assertions.sv]
`default_nettype none
// Timing relations between calls, the global enable and register reads.
module isc_irq_ctrl_chk (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic       re_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] pull_high_sel_i,
  input wire logic [1:0] pull_high_o,
  input wire logic       stack_full_i,
  input wire logic       return_from_irq_i,
  input wire logic       irq_call_o,
  input wire logic [3:0] irq_vector_o,
  input wire logic       global_irq_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // A call is only taken with the global enable up and stack room left.
  property p_call_ok;
    irq_call_o |-> $past(global_irq_enable_o) && !$past(stack_full_i);
  endproperty
  a_call_ok: assert property (p_call_ok)
    else $error("call without enable or stack room");
  property p_call_clr;
    irq_call_o |-> !global_irq_enable_o;
  endproperty
  a_call_clr: assert property (p_call_clr)
    else $error("global enable still set after call");
  property p_one_call;
    irq_call_o |=> !irq_call_o;
  endproperty
  a_one_call: assert property (p_one_call)
    else $error("call lasted more than one cycle");
  property p_full;
    stack_full_i |=> !irq_call_o;
  endproperty
  a_full: assert property (p_full)
    else $error("call while stack full");
  property p_ret;
    return_from_irq_i && !global_irq_enable_o |=> global_irq_enable_o;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not restore global enable");
  // Unused register bits must read as zero whatever was written.
  property p_psc_bits;
    re_i && addr_i == isc_pkg::OFF_PSC |=> rdata_o[7:2] == 6'h00;
  endproperty
  a_psc_bits: assert property (p_psc_bits)
    else $error("prescaler select upper bits not zero");
  property p_tbc_bits;
    re_i && (addr_i == isc_pkg::OFF_TB0 || addr_i == isc_pkg::OFF_TB1)
      |=> rdata_o[6:3] == 4'h0;
  endproperty
  a_tbc_bits: assert property (p_tbc_bits)
    else $error("time base control middle bits not zero");
  // The pull-up follows its selection one cycle late, interrupt use or not.
  property p_pull;
    !$past(sys_rst_i) |-> pull_high_o == $past(pull_high_sel_i);
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-high does not follow selection");
  property p_vec;
    !irq_call_o |-> $stable(irq_vector_o);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector changed without a call");
endmodule
bind isc_irq_ctrl isc_irq_ctrl_chk isc_irq_ctrl_chk_inst (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .re_i(re_i),
  .rdata_o(rdata_o), .pull_high_sel_i(pull_high_sel_i),
  .pull_high_o(pull_high_o), .stack_full_i(stack_full_i),
  .return_from_irq_i(return_from_irq_i), .irq_call_o(irq_call_o),
  .irq_vector_o(irq_vector_o), .global_irq_enable_o(global_irq_enable_o));
`default_nettype wire

// [verification/isc_seq_model.sv]
`default_nettype none
// Sequencer stand-in: each call opens a short service routine that ends
// in a return, so the global enable comes back without software help.
module isc_seq_model #(
  parameter int SERVICE = 4
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic irq_call_i,
  output logic      return_from_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // The return is a one-cycle pulse at the end of the service count.
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      return_from_irq_o <= 1'b0;
    end else begin
      return_from_irq_o <= (cnt == 1);
      if (irq_call_i)
        cnt <= SERVICE;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_isc_irq_ctrl.sv]
`default_nettype none
// Register, event, pin and time base tests for the interrupt block.
module tb_isc_irq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       we_i = 1'b0;
  logic       re_i = 1'b0;
  logic [1:0] pins = 2'h0;
  logic [1:0] is_in = 2'h3;
  logic [1:0] func = 2'h3;
  logic [1:0] pull = 2'h0;
  logic [5:0] evt = 6'h00;
  logic       slow = 1'b0;
  logic       full = 1'b0;
  logic [2:0] scnt = 3'h0;
  logic [7:0] rdata_o;
  logic [1:0] pull_high_o;
  logic [3:0] irq_vector_o;
  logic       ret, irq_call_o, global_irq_enable_o, wake_o;
  int         mismatches = 0;
  int         checks_done = 0;
  int         n;
  logic [7:0] evvec [6] = '{8'h02, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08};
  int         tbn [4] = '{256, 512, 1024, 1280};

  always #4 clock_i = ~clock_i;
  // Slow clock enable, one cycle in five.
  always @(posedge clock_i) begin
    scnt <= (scnt == 3'h4) ? 3'h0 : scnt + 3'h1;
    slow <= (scnt == 3'h4);
  end

  isc_irq_ctrl isc_irq_ctrl_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .ext_irq_pins_i(pins), .pin_is_input_i(is_in), .pin_func_irq_i(func),
    .pull_high_sel_i(pull), .pull_high_o(pull_high_o),
    .timer_a_ovf_i(evt[0]), .timer_b_ovf_i(evt[1]),
    .period_match_i(evt[2]), .duty_match_i(evt[3]),
    .low_supply_i(evt[4]), .nvm_write_done_i(evt[5]),
    .slow_aux_tick_i(slow), .stack_full_i(full),
    .return_from_irq_i(ret), .irq_call_o(irq_call_o),
    .irq_vector_o(irq_vector_o), .global_irq_enable_o(global_irq_enable_o),
    .wake_o(wake_o));
  isc_seq_model isc_seq_model_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .irq_call_i(irq_call_o),
    .return_from_irq_o(ret));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    we_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    re_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge clock_i);
    evt[k] <= 1'b1;
    @(posedge clock_i);
    evt[k] <= 1'b0;
  endtask
  // Returns lim + 1 when no call came in time.
  task automatic wait_call(input int lim, output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      #1 c = c + 1;
    end while (irq_call_o !== 1'b1 && c <= lim);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    pull <= 2'h2;
    for (int a = 0; a < 8; a++)
      rc(3'(a), 8'h00);
    chk({6'h00, pull_high_o}, 8'h02);
    wr(isc_pkg::OFF_PSC, 8'hff);
    wr(isc_pkg::OFF_TB0, 8'hff);
    wr(isc_pkg::OFF_TB1, 8'hff);
    rc(isc_pkg::OFF_PSC, 8'h03);
    rc(isc_pkg::OFF_TB0, 8'h87);
    rc(isc_pkg::OFF_TB1, 8'h87);
    wr(isc_pkg::OFF_TB0, 8'h00);
    wr(isc_pkg::OFF_TB1, 8'h00);
    // Each of the six peripheral event inputs in turn, each serviced two cycles after its pulse.
    wr(isc_pkg::OFF_EN_LO, 8'hff);
    for (int k = 0; k < 6; k++) begin
      wr(isc_pkg::OFF_EN_HI, 8'h03);
      pulse(k);
      wait_call(8, n);
      chkn(n, 1);
      chk({4'h0, irq_vector_o}, evvec[k]);
      chk({7'h0, global_irq_enable_o}, 8'h00);
      rc(isc_pkg::OFF_FLAG_LO, 8'h00);
      rc(isc_pkg::OFF_FLAG_HI, 8'h00);
    end
    // A full stack holds the request pending until it empties.
    @(posedge clock_i);
    full <= 1'b1;
    pulse(2);
    wait_call(20, n);
    chkn(n, 21);
    rc(isc_pkg::OFF_FLAG_LO, 8'h08);
    @(posedge clock_i);
    full <= 1'b0;
    wait_call(8, n);
    chk({4'h0, irq_vector_o}, 8'h03);
    repeat (8) @(posedge clock_i);
    // Enables off: the flag still sets and wakes, but no call follows.
    wr(isc_pkg::OFF_EN_HI, 8'h00);
    wr(isc_pkg::OFF_EN_LO, 8'h00);
    pulse(4);
    #1 chk({7'h0, wake_o}, 8'h01);
    wait_call(20, n);
    chkn(n, 21);
    rc(isc_pkg::OFF_FLAG_LO, 8'h20);
    wr(isc_pkg::OFF_FLAG_LO, 8'h00);
    // Each edge code on each pin; code 4 is both edges on a non-input pin.
    wr(isc_pkg::OFF_EN_LO, 8'h03);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 5; c++) begin
        @(posedge clock_i);
        is_in <= (c == 4) ? 2'h0 : 2'h3;
        wr(isc_pkg::OFF_EDGE, 8'(((c == 4) ? 3 : c) << (2 * p)));
        for (int e = 0; e < 2; e++) begin
          @(posedge clock_i);
          pins[p] <= ~pins[p];
          repeat (6) @(posedge clock_i);
          rc(isc_pkg::OFF_FLAG_LO, (c < 4 && c[e]) ? (8'h01 << p) : 8'h00);
          wr(isc_pkg::OFF_FLAG_LO, 8'h00);
        end
      end
    // Time base periods measured between two successive calls.
    wr(isc_pkg::OFF_EN_LO, 8'hc0);
    wr(isc_pkg::OFF_EN_HI, 8'h02);
    for (int t = 0; t < 4; t++) begin
      wr(isc_pkg::OFF_TB0, 8'h00);
      wr(isc_pkg::OFF_TB1, 8'h00);
      wr(isc_pkg::OFF_PSC, (t < 2) ? 8'h00 : 8'(t - 1));
      wr((t < 2) ? isc_pkg::OFF_TB0 : isc_pkg::OFF_TB1, (t == 1) ? 8'h81 : 8'h80);
      wait_call(3000, n);
      wait_call(3000, n);
      chkn(n, tbn[t]);
      chk({4'h0, irq_vector_o}, (t < 2) ? 8'h06 : 8'h07);
    end
    wr(isc_pkg::OFF_TB1, 8'h00);
    wait_call(1400, n);
    chkn(n, 1401);
    results();
  end
endmodule
`default_nettype wire
